// File: hw/dacs_seq.sv
// Channel selection, sequencer and averaging enable with an APB register file.
// Assumes APB3 master on pclk; frame select and converter data are synchronous inputs.
`timescale 1ns/1ns
`default_nettype none
module dacs_seq
   import dacs_pkg::*;
#(
   parameter int SAMPLE_W = DACS_SAMPLE_W
)
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic frame_sel_n,
   input wire logic [SAMPLE_W-1:0] conv_a_data,
   input wire logic [SAMPLE_W-1:0] conv_b_data,
   output logic pair_sel_out,
   output logic conv_start,
   output logic avg_enable,
   output logic sdo_a,
   output logic sdo_b
);
   // ==========================================================
   // Register file
   // ==========================================================
   logic [DACS_SETUP_W-1:0] setup_r;
   logic [31:0] conv_cnt_r;
   logic [31:0] prdata_r;
   logic pslverr_r;
   logic frame_sel_d_r;
   logic seq_pos_r;
   logic seq_en_d_r;
   logic pair_r;
   logic start_r;
   logic wr_en;
   logic addr_ok;
   logic fs_fall;
   logic seq_en;
   logic pair_now;
   dacs_res_if res ();

   assign wr_en = psel && penable && pwrite;
   assign addr_ok = (paddr == DACS_SETUP_ADDR) || (paddr == DACS_STATUS_ADDR) ||
                    (paddr == DACS_RESULT_ADDR) || (paddr == DACS_CONV_CNT_ADDR);
   assign pready = 1'b1;
   assign prdata = prdata_r;
   assign pslverr = pslverr_r;

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         setup_r <= DACS_SETUP_RST;
      else if (wr_en && (paddr == DACS_SETUP_ADDR))
         setup_r <= pwdata[DACS_SETUP_W-1:0];
   end

   // Read data is registered at the setup-phase edge, so it is valid during the access phase;
   // pready is always high, so the master takes it from the register one edge later.
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         prdata_r <= 32'h00000000;
         pslverr_r <= 1'b0;
      end
      else if (psel && !penable)
      begin
         pslverr_r <= !addr_ok;
         case (paddr)
            DACS_SETUP_ADDR: prdata_r <= {{(32-DACS_SETUP_W){1'b0}}, setup_r};
            DACS_STATUS_ADDR:
            begin
               prdata_r <= 32'h00000000;
               prdata_r[DACS_ST_PAIR_BIT] <= pair_r;
               prdata_r[DACS_ST_AVG_BIT] <= avg_enable;
               prdata_r[DACS_ST_BUSY_BIT] <= res.busy;
            end
            DACS_RESULT_ADDR: prdata_r <= res.result;
            DACS_CONV_CNT_ADDR: prdata_r <= conv_cnt_r;
            default: prdata_r <= DACS_SLAVE_ERR_DATA;
         endcase
      end
   end

   // ==========================================================
   // Conversion start and pair selection
   // ==========================================================
   assign fs_fall = frame_sel_d_r && !frame_sel_n;
   assign seq_en = setup_r[DACS_SEQ_BIT];
   // Manual mode follows the pair-select bit; the sequencer overrides it.
   assign pair_now = seq_en ? seq_pos_r : setup_r[DACS_PAIR_BIT];

   // Averaging only with mode set and a nonzero ratio; otherwise off.
   assign avg_enable = setup_r[DACS_MODE_BIT] &&
      (setup_r[DACS_RATIO_LSB +: DACS_RATIO_W] != DACS_RATIO_OFF);

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         frame_sel_d_r <= 1'b1;
      else
         frame_sel_d_r <= frame_sel_n;
   end

   // Sequence position restarts at pair zero whenever sequencing is switched on.
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         seq_pos_r <= 1'b0;
         seq_en_d_r <= 1'b0;
      end
      else
      begin
         seq_en_d_r <= seq_en;
         if (!seq_en || !seq_en_d_r)
            seq_pos_r <= 1'b0;
         else if (fs_fall)
            seq_pos_r <= ~seq_pos_r;
      end
   end

   // The pair in use is latched on the start edge so the mux holds through the conversion.
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         pair_r <= 1'b0;
         start_r <= 1'b0;
         conv_cnt_r <= 32'h00000000;
      end
      else
      begin
         start_r <= fs_fall;
         if (fs_fall)
         begin
            pair_r <= pair_now;
            conv_cnt_r <= conv_cnt_r + 32'h00000001;
         end
      end
   end

   assign pair_sel_out = pair_r;
   assign conv_start = start_r;

   // ==========================================================
   // Result output
   // ==========================================================
   assign res.start = start_r;
   assign res.word = {conv_a_data, conv_b_data};
   assign sdo_a = res.sdo_a;
   assign sdo_b = res.sdo_b;

   dacs_shifter #(.SAMPLE_W(SAMPLE_W)) u_shifter (
      .pclk(pclk),
      .presetn(presetn),
      .res(res)
   );
endmodule
`default_nettype wire

// File: common/dacs_pkg.sv
// Constants, register map and encodings of the dual converter channel sequencer.
// Assumes a 32-bit APB master and a single clock domain on pclk.
//
// Contract
// - Pair-select zero converts input pair zero on both converters simultaneously.
// - Pair-select one routes input pair one to both converters simultaneously.
// - Sequence-enable bit zero disables sequencing; one enables it.
// - While sequencing, the pair-select bit is ignored for pair choice.
// - Sequencing begins with pair zero, then advances to pair one; a frame fall in the first enabled cycle makes the next frame pair zero too.
// - After pair one, sequencer returns to pair zero and repeats forever.
// - Averaging enabled only with mode bit one and nonzero ratio code.
// - Averaging disabled when mode bit and ratio field are written zero.
// - Conversion starts on the falling edge of active-low frame select.
// - Results are presented most significant bit first, straight binary.
package dacs_pkg;
   // ==========================================================
   // Register map (byte addresses)
   // ==========================================================
   localparam logic [11:0] DACS_SETUP_ADDR = 12'h000;
   localparam logic [11:0] DACS_STATUS_ADDR = 12'h004;
   localparam logic [11:0] DACS_RESULT_ADDR = 12'h008;
   localparam logic [11:0] DACS_CONV_CNT_ADDR = 12'h00c;
   // ==========================================================
   // Primary setup register fields
   // ==========================================================
   localparam int DACS_RATIO_LSB = 0;
   localparam int DACS_RATIO_W = 3;
   localparam int DACS_MODE_BIT = 3;
   localparam int DACS_SEQ_BIT = 4;
   localparam int DACS_PAIR_BIT = 5;
   localparam int DACS_SETUP_W = 6;
   localparam logic [5:0] DACS_SETUP_RST = 6'h00;
   localparam logic [2:0] DACS_RATIO_OFF = 3'h0;
   // Status register fields.
   localparam int DACS_ST_PAIR_BIT = 0;
   localparam int DACS_ST_AVG_BIT = 1;
   localparam int DACS_ST_BUSY_BIT = 2;
   localparam int DACS_SAMPLE_W = 16;
   localparam logic [31:0] DACS_SLAVE_ERR_DATA = 32'h00000000;
   typedef enum logic [1:0] {
      DACS_IDLE = 2'b00,
      DACS_SHIFT = 2'b01,
      DACS_DONE = 2'b10
   } dacs_state_t;
endpackage

// File: common/dacs_res_if.sv
// Result path between the sequencer and the result shifter.
// Assumes both ends run on pclk.
`timescale 1ns/1ns
`default_nettype none
interface dacs_res_if;
   logic start;
   logic [31:0] word;
   logic busy;
   logic sdo_a;
   logic sdo_b;
   logic [31:0] result;
   modport ctl (output start, output word, input busy, input sdo_a, input sdo_b, input result);
   modport shf (input start, input word, output busy, output sdo_a, output sdo_b, output result);
endinterface
`default_nettype wire

// File: hw/dacs_shifter.sv
// Shifts a pair of conversion results out serially, most significant bit first.
// Assumes start is a one-cycle pulse and word holds both results (A high, B low).
`timescale 1ns/1ns
`default_nettype none
module dacs_shifter
   import dacs_pkg::*;
#(
   parameter int SAMPLE_W = DACS_SAMPLE_W
)
(
   input wire logic pclk,
   input wire logic presetn,
   dacs_res_if.shf res
);
   dacs_state_t state_r;
   logic [SAMPLE_W-1:0] sh_a_r;
   logic [SAMPLE_W-1:0] sh_b_r;
   logic [$clog2(SAMPLE_W+1)-1:0] cnt_r;
   logic [31:0] result_r;

   assign res.busy = (state_r != DACS_IDLE);
   // Straight binary, first bit out is the top bit.
   assign res.sdo_a = sh_a_r[SAMPLE_W-1];
   assign res.sdo_b = sh_b_r[SAMPLE_W-1];
   assign res.result = result_r;

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         state_r <= DACS_IDLE;
         sh_a_r <= '0;
         sh_b_r <= '0;
         cnt_r <= '0;
         result_r <= 32'h00000000;
      end
      else
      begin
         case (state_r)
            DACS_IDLE:
            begin
               if (res.start)
               begin
                  sh_a_r <= res.word[2*SAMPLE_W-1:SAMPLE_W];
                  sh_b_r <= res.word[SAMPLE_W-1:0];
                  result_r <= res.word;
                  cnt_r <= '0;
                  state_r <= DACS_SHIFT;
               end
            end
            DACS_SHIFT:
            begin
               sh_a_r <= {sh_a_r[SAMPLE_W-2:0], 1'b0};
               sh_b_r <= {sh_b_r[SAMPLE_W-2:0], 1'b0};
               cnt_r <= cnt_r + 1'b1;
               if (cnt_r == ($clog2(SAMPLE_W+1))'(SAMPLE_W - 1))
                  state_r <= DACS_DONE;
            end
            DACS_DONE:
               state_r <= DACS_IDLE;
            default:
               state_r <= DACS_IDLE;
         endcase
      end
   end
endmodule
`default_nettype wire

// File: bench/dacs_conv_model.sv
// Converter front end: one fixed {A,B} word per input pair.
// Assumes the sequencer takes the data while its start pulse is high.
`timescale 1ns/1ns
`default_nettype none
module dacs_conv_model #(
   parameter logic [31:0] W0 = 32'h0,
   parameter logic [31:0] W1 = 32'h0
)
(
   input wire logic pair_sel,
   output logic [15:0] a_data,
   output logic [15:0] b_data
);
   // Distinct words per pair expose a wrong mux choice on either converter.
   assign {a_data, b_data} = pair_sel ? W1 : W0;
endmodule
`default_nettype wire

// File: bench/dacs_seq_props.sv
// Port assertions for the sequencer, bound into dacs_seq.
// Assumes the setup register changes only by APB writes.
`timescale 1ns/1ns
`default_nettype none
module dacs_seq_chk
   import dacs_pkg::*;
#(
   parameter int SAMPLE_W = DACS_SAMPLE_W
)
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic frame_sel_n,
   input wire logic [SAMPLE_W-1:0] conv_a_data,
   input wire logic pair_sel_out,
   input wire logic conv_start,
   input wire logic avg_enable,
   input wire logic sdo_a
);
   logic wr;
   logic [5:0] cfg_r;
   logic first_r;
   assign wr = psel && penable && pwrite && paddr == DACS_SETUP_ADDR;
   always_ff @(posedge pclk or negedge presetn)
      if (!presetn)
         cfg_r <= '0;
      else if (wr)
         cfg_r <= pwdata[5:0];
   // Marks that the next start is the first one since sequencing was switched on.
   always_ff @(posedge pclk or negedge presetn)
      if (!presetn)
         first_r <= 1'b0;
      else if (wr)
         first_r <= pwdata[4] && (first_r || !cfg_r[4]);
      else if (conv_start)
         first_r <= 1'b0;
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   start_on_fall_a: assert property (
      $fell(frame_sel_n) |=> conv_start) else $error("start missing");
   manual_pair_a: assert property (
      conv_start && !cfg_r[4] |-> pair_sel_out == cfg_r[5]) else $error("manual pair");
   seq_first_a: assert property (
      conv_start && first_r |-> !pair_sel_out) else $error("first pair");
   seq_step_a: assert property (
      conv_start && cfg_r[4] && !first_r |-> pair_sel_out != $past(pair_sel_out))
      else $error("pair step");
   pair_hold_a: assert property (
      !conv_start |-> $stable(pair_sel_out)) else $error("pair moved");
   avg_on_a: assert property (
      cfg_r[3] && cfg_r[2:0] != 3'h0 |-> avg_enable) else $error("avg off");
   avg_off_a: assert property (
      !(cfg_r[3] && cfg_r[2:0] != 3'h0) |-> !avg_enable) else $error("avg on");
   msb_first_a: assert property (
      conv_start |=> (sdo_a == $past(conv_a_data[SAMPLE_W-1]))
      ##1 (sdo_a == $past(conv_a_data[SAMPLE_W-2], 2))) else $error("bit order");
   cover property (conv_start && cfg_r[4]);
   cover property (conv_start && cfg_r[5] && !cfg_r[4]);
   cover property (avg_enable);
endmodule
bind dacs_seq dacs_seq_chk #(.SAMPLE_W(SAMPLE_W)) i_dacs_seq_chk (.pclk(pclk),
   .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
   .pwdata(pwdata), .frame_sel_n(frame_sel_n), .conv_a_data(conv_a_data),
   .pair_sel_out(pair_sel_out), .conv_start(conv_start), .avg_enable(avg_enable),
   .sdo_a(sdo_a));
`default_nettype wire

// File: bench/test_dual_adc_channel_sequencer.sv
// Bench for the sequencer: APB set-up, frame starts and serial result checks.
// Assumes a converter model keyed by the selected pair; only the bench timeout ends a wait.
`timescale 1ns/1ns
`default_nettype none
module test_dual_adc_channel_sequencer
   import dacs_pkg::*;
;
   localparam logic [31:0] W0 = 32'ha0c3b03c;
   localparam logic [31:0] W1 = 32'ha15eb1e5;
   logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic frame_sel_n = 1'b1, pready, pslverr, pair_sel_out, conv_start, avg_enable;
   logic sdo_a, sdo_b, e;
   logic [11:0] paddr = '0;
   logic [31:0] pwdata = '0, prdata, q;
   logic [15:0] ca, cb, sa, sb;
   int errors = 0, checks = 0, cyc = 0;
   dacs_seq i_dacs_seq (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .frame_sel_n(frame_sel_n), .conv_a_data(ca), .conv_b_data(cb),
      .pair_sel_out(pair_sel_out), .conv_start(conv_start), .avg_enable(avg_enable),
      .sdo_a(sdo_a), .sdo_b(sdo_b));
   dacs_conv_model #(.W0(W0), .W1(W1)) i_dacs_conv_model (.pair_sel(pair_sel_out),
      .a_data(ca), .b_data(cb));
   initial
      forever #10 pclk = ~pclk;
   always @(posedge pclk)
   begin
      cyc++;
      if (cyc == 8000)
      begin
         errors++;
         print_verdict();
      end
   end
   task automatic print_verdict;
      if (errors == 0 && checks > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp)
      begin
         errors++;
         $display("FAIL %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do
         @(posedge pclk);
      while (pready !== 1'b1);
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   // Frames sit 199 cycles apart so a pair change always has time to settle.
   task automatic run(input logic [5:0] c, input logic [3:0] ps, input int n);
      apb(1'b1, DACS_SETUP_ADDR, {26'h0, c});
      for (int f = 0; f < n; f++)
      begin
         @(posedge pclk);
         frame_sel_n <= 1'b0;
         do
            @(posedge pclk);
         while (conv_start !== 1'b1);
         chk({31'h0, pair_sel_out}, {31'h0, ps[f]});
         for (int i = 15; i >= 0; i--)
         begin
            @(posedge pclk);
            frame_sel_n <= 1'b1;
            sa[i] = sdo_a;
            sb[i] = sdo_b;
         end
         chk({sa, sb}, ps[f] ? W1 : W0);
         repeat (180) @(posedge pclk);
      end
   endtask
   initial
   begin
      repeat (10) @(posedge pclk);
      presetn <= 1'b1;
      apb(1'b0, DACS_SETUP_ADDR, 32'h0);
      chk(q, 32'h0);
      apb(1'b1, 12'h010, 32'h3f);
      chk({31'h0, e}, 32'h1);
      run(6'h00, 4'b0000, 1);
      run(6'h20, 4'b0011, 2);
      run(6'h30, 4'b1010, 4);
      run(6'h20, 4'b0001, 1);
      run(6'h10, 4'b0010, 2);
      for (int i = 0; i < 16; i++)
      begin
         apb(1'b1, DACS_SETUP_ADDR, 32'(i));
         @(posedge pclk);
         chk({31'h0, avg_enable}, 32'(i > 8));
      end
      // A second reset in mid-run stands in for the host's reset after power-up.
      @(posedge pclk);
      presetn <= 1'b0;
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      apb(1'b0, DACS_STATUS_ADDR, 32'h0);
      chk(q, 32'h00000000);
      apb(1'b0, DACS_CONV_CNT_ADDR, 32'h0);
      chk(q, 32'h00000000);
      run(6'h1b, 4'b0000, 1);
      apb(1'b0, DACS_RESULT_ADDR, 32'h0);
      chk(q, W0);
      apb(1'b0, DACS_STATUS_ADDR, 32'h0);
      chk(q, 32'h00000002);
      apb(1'b0, DACS_CONV_CNT_ADDR, 32'h0);
      chk(q, 32'h00000001);
      print_verdict();
   end
endmodule
`default_nettype wire
